// File: pmcd_pkg.sv
package pmcd_pkg;
  localparam logic [31:0] PMCD_ADDR_CONTROL = 32'hffff_0408;
  localparam logic [31:0] PMCD_ADDR_PREKEY = 32'hffff_0404;
  localparam logic [31:0] PMCD_ADDR_POSTKEY = 32'hffff_040c;
  localparam logic [31:0] PMCD_KEY_VALUE = 32'h0000_0001;
  localparam logic [7:0] PMCD_CONTROL_RESET = 8'h79;
  localparam int PMCD_BIT_PREC_OSC = 7;
  localparam int PMCD_BIT_XTAL = 6;
  localparam int PMCD_BIT_PLL = 5;
  localparam int PMCD_BIT_PERIPH = 4;
  localparam int PMCD_BIT_CORE = 3;
  localparam int PMCD_DIV_MSB = 2;
  localparam int PMCD_DIV_W = 3;
  localparam int PMCD_DIV_MAX_EXP = 7;
  typedef enum logic [2:0] {
    PMCD_KEY_IDLE = 3'b001,
    PMCD_KEY_ARMED = 3'b010,
    PMCD_KEY_STAGED = 3'b100
  } pmcd_key_state_t;
endpackage

// File: pmcd_power_mode_clock_divider.sv
// Behaviour
// - Bit 7 gates precision oscillator input
// - Bit 6 gates crystal circuitry
// - PLL enable resets set, wake sets
// - PLL off only with core, peripherals off
// - PLL-clocked timers stop with PLL
// - Peripheral enable resets set, gates peripherals
// - Peripherals off only with core off
// - LIN wake detection stays powered
// - Wake-up timer runs on low-power oscillator
// - Core enable resets set, wake sets
// - Core clock is base divided by 2^code
// - Divider resets to 001, register 0x79
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module pmcd_power_mode_clock_divider
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wakeEvent,
  input wire logic timerFromPll,
  input wire logic lowPowerOscSelected,
  output logic precOscInputEn,
  output logic xtalEn,
  output logic pllEn,
  output logic periphEn,
  output logic coreEn,
  output logic linWakeEn,
  output logic wakeupTimerEn,
  output logic timerEn,
  output logic coreClkEn
);
  import pmcd_pkg::*;

  logic [7:0] control_q;
  logic [7:0] staged_q;
  pmcd_key_state_t keyState_q;
  logic [PMCD_DIV_MAX_EXP-1:0] divCount_q;
  logic [2:0] wakeSync_q;
  logic wakeLevel_q;
  logic access;
  logic wrCommit;
  logic [7:0] stagedFixed;

  assign access = psel && penable;

  // Wake pin sampled through three flops; level changes once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeSync_q <= 3'b000;
      wakeLevel_q <= 1'b0;
    end else begin
      wakeSync_q <= {wakeSync_q[1:0], wakeEvent};
      if (wakeSync_q[1] == wakeSync_q[2]) begin
        wakeLevel_q <= wakeSync_q[2];
      end
    end
  end

  logic wakeRise;
  logic wakePrev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakePrev_q <= 1'b0;
    end else begin
      wakePrev_q <= wakeLevel_q;
    end
  end
  assign wakeRise = wakeLevel_q && !wakePrev_q;

  // Enables that must stay on while a higher one is on are forced up
  always_comb begin
    stagedFixed = staged_q;
    if (stagedFixed[PMCD_BIT_CORE]) begin
      stagedFixed[PMCD_BIT_PERIPH] = 1'b1;
    end
    if (stagedFixed[PMCD_BIT_CORE] || stagedFixed[PMCD_BIT_PERIPH]) begin
      stagedFixed[PMCD_BIT_PLL] = 1'b1;
    end
  end

  // Key sequence: prewrite key, control write, postwrite key
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyState_q <= PMCD_KEY_IDLE;
      staged_q <= PMCD_CONTROL_RESET;
    end else if (access && pwrite) begin
      case (keyState_q)
        PMCD_KEY_IDLE: begin
          if (paddr == PMCD_ADDR_PREKEY && pwdata == PMCD_KEY_VALUE) begin
            keyState_q <= PMCD_KEY_ARMED;
          end
        end
        PMCD_KEY_ARMED: begin
          if (paddr == PMCD_ADDR_CONTROL) begin
            staged_q <= pwdata[7:0];
            keyState_q <= PMCD_KEY_STAGED;
          end else begin
            keyState_q <= PMCD_KEY_IDLE;
          end
        end
        PMCD_KEY_STAGED: begin
          keyState_q <= PMCD_KEY_IDLE;
        end
        default: begin
          keyState_q <= PMCD_KEY_IDLE;
        end
      endcase
    end
  end

  assign wrCommit = access && pwrite && keyState_q == PMCD_KEY_STAGED
    && paddr == PMCD_ADDR_POSTKEY && pwdata == PMCD_KEY_VALUE;

  // Control register: keyed write, wake sets the three enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= PMCD_CONTROL_RESET;
    end else if (wakeRise) begin
      control_q[PMCD_BIT_PLL] <= 1'b1;
      control_q[PMCD_BIT_PERIPH] <= 1'b1;
      control_q[PMCD_BIT_CORE] <= 1'b1;
    end else if (wrCommit) begin
      control_q <= stagedFixed;
    end
  end

  // Core clock enable pulse, one in 2^code cycles of the base clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount_q <= '0;
      coreClkEn <= 1'b0;
    end else begin
      divCount_q <= divCount_q + 1'b1;
      coreClkEn <= control_q[PMCD_BIT_CORE] && (((divCount_q + 1'b1)
        & ((PMCD_DIV_MAX_EXP'(1) << control_q[PMCD_DIV_MSB:0]) - 1'b1)) == '0);
    end
  end

  // Power gating outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      precOscInputEn <= 1'b0;
      xtalEn <= 1'b1;
      pllEn <= 1'b1;
      periphEn <= 1'b1;
      coreEn <= 1'b1;
      linWakeEn <= 1'b1;
      wakeupTimerEn <= 1'b1;
      timerEn <= 1'b1;
    end else begin
      precOscInputEn <= control_q[PMCD_BIT_PREC_OSC];
      xtalEn <= control_q[PMCD_BIT_XTAL];
      pllEn <= control_q[PMCD_BIT_PLL];
      periphEn <= control_q[PMCD_BIT_PERIPH];
      coreEn <= control_q[PMCD_BIT_CORE];
      linWakeEn <= 1'b1;
      wakeupTimerEn <= control_q[PMCD_BIT_PERIPH] || lowPowerOscSelected;
      timerEn <= control_q[PMCD_BIT_PLL] || !timerFromPll;
    end
  end

  // APB slave: zero wait states, unmapped access flags an error
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == PMCD_ADDR_CONTROL
        || (pwrite && (paddr == PMCD_ADDR_PREKEY || paddr == PMCD_ADDR_POSTKEY)));
      prdata <= (psel && !penable && !pwrite && paddr == PMCD_ADDR_CONTROL)
        ? {24'h00_0000, control_q} : '0;
    end
  end

  // Cycle counts that back the divider rate check
  logic [8:0] pulseGap_q;
  logic [7:0] ctlSteady_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseGap_q <= 9'h001;
      ctlSteady_q <= 8'h00;
    end else begin
      if (coreClkEn) begin
        pulseGap_q <= 9'h001;
      end else if (pulseGap_q != 9'h1FF) begin
        pulseGap_q <= pulseGap_q + 9'h001;
      end
      if (wrCommit || wakeRise) begin
        ctlSteady_q <= 8'h00;
      end else if (ctlSteady_q != 8'hFF) begin
        ctlSteady_q <= ctlSteady_q + 8'h01;
      end
    end
  end

  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  pll_order_a: assert property (pllEn || (!periphEn && !coreEn))
    else $error("PLL off while core or peripherals on");
  periph_order_a: assert property (periphEn || !coreEn)
    else $error("Peripherals off while core on");
  wake_sets_a: assert property (wakeRise |-> ##2 (pllEn && periphEn && coreEn))
    else $error("Wake did not restore enables");
  wake_keeps_a: assert property (wakeRise && !wrCommit |=>
    control_q[7:6] == $past(control_q[7:6]) && control_q[2:0] == $past(control_q[2:0]))
    else $error("Wake changed other fields");
  keyed_only_a: assert property (!wrCommit && !wakeRise |=> $stable(control_q))
    else $error("Control changed without keyed write");
  prec_follow_a: assert property (##1 precOscInputEn == $past(control_q[7]))
    else $error("Oscillator input enable lag wrong");
  xtal_follow_a: assert property (##1 xtalEn == $past(control_q[6]))
    else $error("Crystal enable lag wrong");
  lin_alive_a: assert property (linWakeEn)
    else $error("LIN wake detection off");
  wtimer_a: assert property (lowPowerOscSelected |=> wakeupTimerEn)
    else $error("Wake-up timer stopped");
  timer_pll_a: assert property (timerFromPll && !control_q[5] |=> !timerEn)
    else $error("PLL timer kept running");
  core_clk_a: assert property (control_q[3] && control_q[2:0] == 3'd0 && $stable(control_q)
    |=> coreClkEn)
    else $error("Undivided core clock missing");
  core_off_a: assert property (!control_q[3] |=> !coreClkEn)
    else $error("Core clock while core off");

  // Bus answer: one-cycle ready, registered data and error
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("Ready missing in access phase");
  ready_once_a: assert property (pready |=> !pready)
    else $error("Ready held past one cycle");
  ready_idle_a: assert property (!psel |=> !pready)
    else $error("Ready without a request");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("Error without ready");
  read_data_a: assert property (psel && !penable && !pwrite
    && paddr == PMCD_ADDR_CONTROL |=> prdata == {24'h00_0000, $past(control_q)})
    else $error("Control read data wrong");
  read_zero_a: assert property (psel && !penable && (pwrite || paddr != PMCD_ADDR_CONTROL)
    |=> prdata == 32'h0000_0000)
    else $error("Read data not zero");
  key_read_err_a: assert property (psel && !penable && !pwrite && paddr == PMCD_ADDR_PREKEY
    |=> pslverr)
    else $error("Key read not refused");
  ctl_err_a: assert property (psel && !penable && paddr == PMCD_ADDR_CONTROL |=> !pslverr)
    else $error("Control access flagged");
  key_write_ok_a: assert property (psel && !penable && pwrite && paddr == PMCD_ADDR_POSTKEY
    |=> !pslverr)
    else $error("Key write flagged");
  unmapped_err_a: assert property (psel && !penable
    && paddr == PMCD_ADDR_CONTROL + 32'h0000_0008 |=> pslverr)
    else $error("Unmapped access not flagged");

  // Key sequence
  key_onehot_a: assert property ($onehot(keyState_q))
    else $error("Key state not one-hot");
  key_arm_a: assert property (keyState_q == PMCD_KEY_IDLE && access && pwrite
    && paddr == PMCD_ADDR_PREKEY && pwdata == PMCD_KEY_VALUE |=> keyState_q == PMCD_KEY_ARMED)
    else $error("Prewrite key not taken");
  key_idle_hold_a: assert property (keyState_q == PMCD_KEY_IDLE
    && !(access && pwrite) |=> keyState_q == PMCD_KEY_IDLE)
    else $error("Key state left idle on its own");
  key_abort_a: assert property (keyState_q == PMCD_KEY_ARMED && access && pwrite
    && paddr != PMCD_ADDR_CONTROL |=> keyState_q == PMCD_KEY_IDLE)
    else $error("Stray write did not abort key");
  key_stage_a: assert property (keyState_q == PMCD_KEY_ARMED && access && pwrite
    && paddr == PMCD_ADDR_CONTROL |=> keyState_q == PMCD_KEY_STAGED
    && staged_q == $past(pwdata[7:0]))
    else $error("Control value not staged");
  key_close_a: assert property (keyState_q == PMCD_KEY_STAGED && access && pwrite
    |=> keyState_q == PMCD_KEY_IDLE)
    else $error("Key sequence not closed");
  key_reads_a: assert property (access && !pwrite |=> $stable(keyState_q))
    else $error("Read moved key state");
  stage_hold_a: assert property (!(access && pwrite
    && keyState_q == PMCD_KEY_ARMED) |=> $stable(staged_q))
    else $error("Staged value changed");

  // Control register updates
  commit_load_a: assert property (wrCommit && !wakeRise
    |=> control_q == $past(stagedFixed))
    else $error("Committed value not loaded");
  periph_forced_a: assert property (wrCommit && !wakeRise
    && staged_q[PMCD_BIT_CORE] |=> control_q[PMCD_BIT_PERIPH])
    else $error("Peripherals cleared with core on");
  pll_forced_a: assert property (wrCommit && !wakeRise
    && (staged_q[PMCD_BIT_CORE] || staged_q[PMCD_BIT_PERIPH]) |=> control_q[PMCD_BIT_PLL])
    else $error("PLL cleared with core or peripherals on");
  all_off_a: assert property (wrCommit && !wakeRise && staged_q[5:3] == 3'b000
    |=> control_q[5:3] == 3'b000)
    else $error("Joint power-down refused");
  wake_wins_a: assert property (wakeRise |=> control_q[5:3] == 3'b111)
    else $error("Wake did not set enables");
  ctl_pll_order_a: assert property (control_q[5] || !(control_q[4] || control_q[3]))
    else $error("Register holds PLL off with users on");
  ctl_periph_order_a: assert property (control_q[4] || !control_q[3])
    else $error("Register holds peripherals off with core on");

  // Enable outputs follow the register one cycle later
  pll_follow_a: assert property (##1 pllEn == $past(control_q[5]))
    else $error("PLL enable lag wrong");
  periph_follow_a: assert property (##1 periphEn == $past(control_q[4]))
    else $error("Peripheral enable lag wrong");
  core_follow_a: assert property (##1 coreEn == $past(control_q[3]))
    else $error("Core enable lag wrong");
  wtimer_periph_a: assert property (control_q[4] |=> wakeupTimerEn)
    else $error("Wake-up timer off with peripherals on");
  wtimer_off_a: assert property (!control_q[4] && !lowPowerOscSelected
    |=> !wakeupTimerEn)
    else $error("Wake-up timer kept running");
  timer_free_a: assert property (!timerFromPll |=> timerEn)
    else $error("Timer on live source stopped");
  timer_pll_on_a: assert property (control_q[5] |=> timerEn)
    else $error("Timer stopped with PLL on");
  wake_pulse_a: assert property (wakeRise |=> !wakeRise)
    else $error("Wake edge longer than one cycle");
  core_clk_src_a: assert property (coreClkEn |-> $past(control_q[PMCD_BIT_CORE]))
    else $error("Core clock pulse without core on");

  // Divider rate once the register has been steady for a while
  core_clk_gap_a: assert property (coreClkEn && ctlSteady_q == 8'hFF
    |-> pulseGap_q == (9'h001 << control_q[PMCD_DIV_MSB:0]))
    else $error("Core clock period wrong for divider code");

  cover_commit_c: cover property (wrCommit);
  cover_abort_c: cover property (keyState_q == PMCD_KEY_ARMED && access && pwrite
    && paddr != PMCD_ADDR_CONTROL);
  cover_div_max_c: cover property (coreClkEn && control_q[2:0] == 3'h7);
  cover_wake_c: cover property (wakeRise && !coreEn);
  cover_pll_off_c: cover property (!pllEn);
endmodule

// File: pmcd_power_mode_clock_divider_tb_top.sv
`timescale 1ns/10ps
module pmcd_power_mode_clock_divider_tb_top;
  import pmcd_pkg::*;
  logic sysClk = 1'b0, rstN = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdata;
  logic pready, pslverr, wakeEvent = 1'b0, timerFromPll = 1'b1, lowPowerOscSelected = 1'b0;
  logic precOscInputEn, xtalEn, pllEn, periphEn, coreEn, linWakeEn, wakeupTimerEn, timerEn;
  logic coreClkEn;
  int mismatches = 0, totalChecks = 0, pulses;
  int codes [3] = '{0, 3, 7};
  always #5 sysClk = ~sysClk;
  pmcd_power_mode_clock_divider dut (
    .sys_clk(sysClk), .rst_n(rstN), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakeEvent(wakeEvent), .timerFromPll(timerFromPll),
    .lowPowerOscSelected(lowPowerOscSelected), .precOscInputEn(precOscInputEn),
    .xtalEn(xtalEn), .pllEn(pllEn), .periphEn(periphEn), .coreEn(coreEn),
    .linWakeEn(linWakeEn), .wakeupTimerEn(wakeupTimerEn), .timerEn(timerEn),
    .coreClkEn(coreClkEn)
  );
  task automatic end_sim;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    int i;
    @(posedge sysClk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge sysClk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge sysClk);
      if (pready === 1'h1) break;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 20) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic keyWrite(input logic [7:0] v);
    apb(1'h1, PMCD_ADDR_PREKEY, PMCD_KEY_VALUE);
    apb(1'h1, PMCD_ADDR_CONTROL, {24'h00_0000, v});
    apb(1'h1, PMCD_ADDR_POSTKEY, PMCD_KEY_VALUE);
    repeat (3) @(posedge sysClk);
  endtask
  task automatic readCtl(input string name, input logic [7:0] e);
    apb(1'h0, PMCD_ADDR_CONTROL, 32'h0000_0000);
    check(name, {24'h00_0000, e}, rdata);
  endtask
  task automatic checkEn(input logic [4:0] e);
    check("enables", {27'h000_0000, e},
      {27'h000_0000, precOscInputEn, xtalEn, pllEn, periphEn, coreEn});
  endtask
  initial begin
    repeat (10) @(posedge sysClk);
    rstN <= 1'h1;
    readCtl("reset value", 8'h79);
    checkEn(5'h0F);
    $display("test reset done");
    keyWrite(8'hC7);
    readCtl("power down", 8'hC7);
    checkEn(5'h18);
    check("pll timer", 32'h0000_0000, {31'h0000_0000, timerEn});
    check("wakeup timer off", 32'h0000_0000, {31'h0000_0000, wakeupTimerEn});
    lowPowerOscSelected <= 1'h1;
    repeat (3) @(posedge sysClk);
    check("wakeup timer", 32'h0000_0001, {31'h0000_0000, wakeupTimerEn});
    check("lin wake", 32'h0000_0001, {31'h0000_0000, linWakeEn});
    apb(1'h1, PMCD_ADDR_CONTROL, 32'h0000_0000);
    readCtl("unkeyed write", 8'hC7);
    apb(1'h1, PMCD_ADDR_PREKEY, PMCD_KEY_VALUE);
    apb(1'h1, PMCD_ADDR_POSTKEY, PMCD_KEY_VALUE);
    apb(1'h1, PMCD_ADDR_CONTROL, 32'h0000_0000);
    apb(1'h1, PMCD_ADDR_POSTKEY, PMCD_KEY_VALUE);
    readCtl("aborted key", 8'hC7);
    $display("test power down done");
    wakeEvent <= 1'h1;
    repeat (8) @(posedge sysClk);
    wakeEvent <= 1'h0;
    repeat (4) @(posedge sysClk);
    readCtl("wake", 8'hFF);
    checkEn(5'h1F);
    keyWrite(8'h69);
    readCtl("periph with core", 8'h79);
    keyWrite(8'h59);
    readCtl("pll with core", 8'h79);
    $display("test wake done");
    foreach (codes[k]) begin
      keyWrite(8'h78 | 8'(codes[k]));
      pulses = 0;
      repeat (256) begin
        @(posedge sysClk);
        pulses += int'(coreClkEn === 1'h1);
      end
      check("core clock", 32'(256 >> codes[k]), 32'(pulses));
    end
    $display("test divider done");
    apb(1'h0, 32'hFFFF_0410, 32'h0000_0000);
    check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    check("unmapped data", 32'h0000_0000, rdata);
    $display("test unmapped done");
    end_sim();
  end
endmodule
